// file: logic/prsc_pkg.sv
// Purpose: Shared constants and types for the power, reset and sleep controller
// Assumes: One 125 MHz clock; all pins already synchronous to it
// Notes: Configuration capture width is a module parameter of the controller
package prsc_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned PRSC_CLK_PERIOD_PS = 8000;
   localparam int unsigned PRSC_OUT_RELEASE_CLKS = 2;
   localparam int unsigned PRSC_RST_PIPE_CLKS = 1;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic PRSC_RST_CORE_CLK_EN = 1'b0;
   localparam logic PRSC_RST_BUS_CLK_EN = 1'b0;
   localparam logic PRSC_RST_APIC_CLK_EN = 1'b0;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0]
   {
      PRSC_ST_RESET = 2'b00,
      PRSC_ST_RUN   = 2'b01,
      PRSC_ST_HALT  = 2'b10,
      PRSC_ST_SLEEP = 2'b11
   } prsc_state_t;

   typedef struct packed
   {
      logic core;
      logic bus;
      logic apic;
      logic pll;
   } prsc_clk_en_t;

   typedef struct packed
   {
      logic hard_reset_n;
      logic supply_ok_in;
      logic halt_clock_req_n;
      logic deep_idle_req_n;
      logic snoop_req;
      logic intr_req;
   } prsc_pins_t;

endpackage

// file: logic/prsc_ctrl.sv
// Purpose: Power-good qualification, hard reset, clock-halt and deep idle control
// Assumes: Board logic keeps supply_ok and hard reset timing; one clock domain
// Notes: Clock gating is shown as enable outputs; the clock gates live elsewhere
`timescale 1ns/1ps
`default_nettype none

module prsc_ctrl
   import prsc_pkg::*;
#(
   parameter int unsigned CFG_W = 8
)
(
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_supply_ok_in,
   input wire logic i_hard_reset_n,
   input wire logic i_halt_clock_req_n,
   input wire logic i_deep_idle_req_n,
   input wire logic i_bclk_present,
   input wire logic i_snoop_req,
   input wire logic i_intr_req,
   input wire logic [CFG_W-1:0] i_cfg_pins,
   input wire logic i_bus_out_en_req,
   output logic o_int_reset,
   output logic o_cache_inval,
   output logic o_bus_out_en,
   output logic [CFG_W-1:0] o_cfg_opts,
   output logic o_cfg_valid,
   output logic o_halt_ack,
   output logic o_snoop_accept,
   output logic o_intr_accept,
   output logic o_core_clk_en,
   output logic o_bus_clk_en,
   output logic o_apic_clk_en,
   output logic o_pll_en,
   output logic [1:0] o_state
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed
   {
      prsc_state_t st;
      logic rst_seen;
      logic int_reset;
      logic cache_inval;
      logic bus_out_en;
      logic [CFG_W-1:0] cfg;
      logic cfg_valid;
      logic halt_ack;
      logic snoop_acc;
      logic intr_acc;
      prsc_clk_en_t clk_en;
   } prsc_ctrl_st_t;

   prsc_ctrl_st_t cur_ff;
   prsc_ctrl_st_t nxt_st;
   logic in_reset;

   // Supply loss forces reset whatever the reset pin says
   assign in_reset = !i_supply_ok_in || !i_hard_reset_n;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      nxt_st = cur_ff;
      nxt_st.halt_ack = 1'b0;
      nxt_st.rst_seen = in_reset;
      if (in_reset)
      begin
         // Known state, caches dropped without write-back
         nxt_st.st = PRSC_ST_RESET;
         nxt_st.int_reset = 1'b1;
         nxt_st.cache_inval = 1'b1;
         nxt_st.bus_out_en = 1'b0;
         nxt_st.snoop_acc = 1'b0;
         nxt_st.intr_acc = 1'b0;
         nxt_st.clk_en = '{core: PRSC_RST_CORE_CLK_EN, bus: PRSC_RST_BUS_CLK_EN,
                           apic: PRSC_RST_APIC_CLK_EN, pll: 1'b1};
      end
      else
      begin
         nxt_st.int_reset = 1'b0;
         nxt_st.cache_inval = 1'b0;
         if (cur_ff.rst_seen)
         begin
            // Rising edge of hard reset: latch the straps
            nxt_st.cfg = i_cfg_pins;
            nxt_st.cfg_valid = 1'b1;
         end
         unique case (cur_ff.st)
            PRSC_ST_RESET:
            begin
               nxt_st.st = PRSC_ST_RUN;
               nxt_st.clk_en = '{core: 1'b1, bus: 1'b1, apic: 1'b1, pll: 1'b1};
            end
            PRSC_ST_RUN:
            begin
               if (!i_halt_clock_req_n)
               begin
                  nxt_st.st = PRSC_ST_HALT;
                  nxt_st.halt_ack = 1'b1;
                  nxt_st.clk_en.core = 1'b0;
               end
            end
            PRSC_ST_HALT:
            begin
               if (!i_deep_idle_req_n)
               begin
                  nxt_st.st = PRSC_ST_SLEEP;
                  nxt_st.clk_en = '{core: 1'b0, bus: 1'b0, apic: 1'b0, pll: 1'b1};
               end
               else if (i_halt_clock_req_n)
               begin
                  nxt_st.st = PRSC_ST_RUN;
                  nxt_st.clk_en = '{core: 1'b1, bus: 1'b1, apic: 1'b1, pll: 1'b1};
               end
            end
            PRSC_ST_SLEEP:
            begin
               // Only request release and clock loss matter here; reset above
               if (i_deep_idle_req_n)
               begin
                  nxt_st.st = PRSC_ST_HALT;
                  nxt_st.clk_en = '{core: 1'b0, bus: 1'b1, apic: 1'b1, pll: 1'b1};
               end
               else if (!i_bclk_present)
               begin
                  nxt_st.clk_en.pll = 1'b0;
               end
               else
               begin
                  nxt_st.clk_en.pll = 1'b1;
               end
            end
         endcase
         // Halt keeps snooping and interrupts; sleep ignores both
         nxt_st.snoop_acc = (nxt_st.st != PRSC_ST_SLEEP) && i_snoop_req;
         nxt_st.intr_acc = (nxt_st.st != PRSC_ST_SLEEP) && i_intr_req;
         nxt_st.bus_out_en = i_bus_out_en_req && (nxt_st.st != PRSC_ST_SLEEP);
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_b)
      begin
         cur_ff <= '0;
         cur_ff.st <= PRSC_ST_RESET;
         cur_ff.int_reset <= 1'b1;
         cur_ff.rst_seen <= 1'b1;
      end
      else
      begin
         cur_ff <= nxt_st;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign o_int_reset = cur_ff.int_reset;
   assign o_cache_inval = cur_ff.cache_inval;
   assign o_bus_out_en = cur_ff.bus_out_en;
   assign o_cfg_opts = cur_ff.cfg;
   assign o_cfg_valid = cur_ff.cfg_valid;
   assign o_halt_ack = cur_ff.halt_ack;
   assign o_snoop_accept = cur_ff.snoop_acc;
   assign o_intr_accept = cur_ff.intr_acc;
   assign o_core_clk_en = cur_ff.clk_en.core;
   assign o_bus_clk_en = cur_ff.clk_en.bus;
   assign o_apic_clk_en = cur_ff.clk_en.apic;
   assign o_pll_en = cur_ff.clk_en.pll;
   assign o_state = cur_ff.st;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   sequence s_enter_sleep;
      (o_state == PRSC_ST_HALT) && !i_deep_idle_req_n && !in_reset;
   endsequence

   sequence s_leave_sleep;
      (o_state == PRSC_ST_SLEEP) && i_deep_idle_req_n && !in_reset;
   endsequence

   AST_BUS_RELEASE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      !i_hard_reset_n |-> ##[1:2] !o_bus_out_en)
      else $error("Bus outputs not released after hard reset");
   AST_CACHE_INVAL: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      !i_hard_reset_n |=> o_cache_inval && o_state == PRSC_ST_RESET)
      else $error("Caches not invalidated in reset");
   AST_CFG_CAPTURE: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      ($rose(i_hard_reset_n) && i_supply_ok_in) |=> o_cfg_valid && o_cfg_opts == $past(i_cfg_pins))
      else $error("Configuration not captured at reset release");
   AST_SLEEP_ENTRY: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      s_enter_sleep |=> o_state == PRSC_ST_SLEEP && !o_core_clk_en && !o_bus_clk_en && !o_apic_clk_en)
      else $error("Sleep entry wrong");
   AST_SLEEP_DEAF: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      o_state == PRSC_ST_SLEEP |-> !o_snoop_accept && !o_intr_accept)
      else $error("Snoop or interrupt seen in sleep");
   AST_SLEEP_EXIT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      s_leave_sleep |=> o_state == PRSC_ST_HALT && o_bus_clk_en && o_apic_clk_en
      ##1 (o_state != PRSC_ST_SLEEP || !$past(i_deep_idle_req_n)))
      else $error("Sleep exit wrong");
   AST_SLEEP_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (o_state == PRSC_ST_SLEEP && !i_deep_idle_req_n && !in_reset) |=> o_state == PRSC_ST_SLEEP)
      else $error("Sleep left without cause");
   AST_HALT_ENTRY: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (o_state == PRSC_ST_RUN && !i_halt_clock_req_n && !in_reset)
      |=> o_halt_ack && !o_core_clk_en && o_bus_clk_en && o_apic_clk_en ##1 !o_halt_ack)
      else $error("Halt entry wrong");
   AST_HALT_EXIT: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      (o_state == PRSC_ST_HALT && i_halt_clock_req_n && i_deep_idle_req_n && !in_reset)
      |=> o_state == PRSC_ST_RUN && o_core_clk_en)
      else $error("Halt exit wrong");
   AST_SUPPLY_RESET: assert property (@(posedge i_clk) disable iff (!i_rst_b)
      !i_supply_ok_in |=> o_int_reset)
      else $error("Internal reset not held on supply loss");

endmodule

`default_nettype wire

// file: test/prsc_board.sv
// Purpose: Board power and reset sequencer model
// Assumes: Launches changes on rising edges; the controller sees them one edge later
// Notes: Reset pulse shortened to RST_CLKS cycles
`timescale 1ns/1ps
`default_nettype none
module prsc_board
#(
   parameter int unsigned RST_CLKS = 8
)
(
   input wire logic i_clk,
   input wire logic i_go,
   input wire logic i_cold,
   output logic o_supply_ok_in,
   output logic o_hard_reset_n,
   output logic o_busy
);
   logic [7:0] cnt_ff = 8'h00;
   logic sok_ff = 1'b0;
   logic hrst_n_ff = 1'b0;
   assign o_busy = (cnt_ff != 8'h00);
   assign o_supply_ok_in = sok_ff;
   assign o_hard_reset_n = hrst_n_ff;
   // Supply starts low and is only dropped by a cold cycle, so warm cycles leave it unchanged and every cold cycle drops it again
   always @(posedge i_clk)
   begin
      if (i_go && !o_busy)
      begin
         cnt_ff <= i_cold ? 8'(2 * RST_CLKS) : 8'(RST_CLKS);
         sok_ff <= !i_cold && sok_ff;
         hrst_n_ff <= i_cold && hrst_n_ff;
      end
      else if (o_busy)
      begin
         cnt_ff <= cnt_ff - 8'h01;
         if (cnt_ff == 8'(RST_CLKS + 1))
            {sok_ff, hrst_n_ff} <= 2'b10;
         if (cnt_ff == 8'h01)
            hrst_n_ff <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: test/prsc_ctrl_tb.sv
// Purpose: Self-checking bench for the power, reset and deep idle controller
// Assumes: Bench inputs change at falling edges
// Notes: Board reset pulse shortened to R cycles
`timescale 1ns/1ps
`default_nettype none
module prsc_ctrl_tb;
   import prsc_pkg::*;
   localparam int R = 8;
   logic clk = 1'b0, rst_b = 1'b0, go = 1'b0, cold = 1'b0, halt_n = 1'b1, idle_n = 1'b1;
   logic bclk = 1'b1, snp = 1'b0, intr = 1'b0, oe_req = 1'b0, sok, hrst_n, busy;
   logic int_rst, inval, oe, cfg_ok, hack, snp_acc, intr_acc, core, bus, apic, pll;
   logic [7:0] pins = 8'h00, cap, opts;
   logic [1:0] st;
   logic [31:0] seed = 32'h0000ad7c;
   int fails = 0, compares = 0, cyc = 0;
   prsc_board #(.RST_CLKS(R)) i_board (.i_clk(clk), .i_go(go), .i_cold(cold),
      .o_supply_ok_in(sok), .o_hard_reset_n(hrst_n), .o_busy(busy));
   prsc_ctrl #(.CFG_W(8)) i_dut (.i_clk(clk), .i_rst_b(rst_b), .i_supply_ok_in(sok),
      .i_hard_reset_n(hrst_n), .i_halt_clock_req_n(halt_n), .i_deep_idle_req_n(idle_n),
      .i_bclk_present(bclk), .i_snoop_req(snp), .i_intr_req(intr), .i_cfg_pins(pins),
      .i_bus_out_en_req(oe_req), .o_int_reset(int_rst), .o_cache_inval(inval),
      .o_bus_out_en(oe), .o_cfg_opts(opts), .o_cfg_valid(cfg_ok), .o_halt_ack(hack),
      .o_snoop_accept(snp_acc), .o_intr_accept(intr_acc), .o_core_clk_en(core),
      .o_bus_clk_en(bus), .o_apic_clk_en(apic), .o_pll_en(pll), .o_state(st));
   initial
   begin
      forever #4 clk = ~clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // Core, bus and APIC enables per state
   function automatic logic [2:0] clk_exp(input prsc_state_t s);
      return (s == PRSC_ST_RUN) ? 3'h7 : (s == PRSC_ST_HALT) ? 3'h3 : 3'h0;
   endfunction
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD %s exp %h got %h", name, exp, got);
      end
   endtask
   task automatic chk1(input string name, input logic exp, input logic got);
      chk(name, {7'h00, exp}, {7'h00, got});
   endtask
   task automatic chk_st(input prsc_state_t s);
      chk("state", {6'h00, s}, {6'h00, st});
      chk("clk_en", {5'h00, clk_exp(s)}, {5'h00, core, bus, apic});
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 1500)
      begin
         fails++;
         finish_test();
      end
   end
   initial
   begin
      tick(6);
      rst_b = 1'b1;
      // Cold, warm, then cold with hard reset still high
      for (int k = 0; k < 3; k++)
      begin
         seed = xs(seed);
         pins = (k == 1) ? 8'hff : seed[7:0];
         cap = pins;
         oe_req = 1'b1;
         cold = (k != 1);
         go = 1'b1;
         tick(1);
         go = 1'b0;
         tick(2);
         chk1("bus_out_en", 1'b0, oe);
         chk1("int_reset", 1'b1, int_rst);
         chk1("cache_inval", 1'b1, inval);
         chk_st(PRSC_ST_RESET);
         chk1("cfg_valid", k != 0, cfg_ok);
         for (int w = 0; w < 4 * R && busy; w++)
            tick(1);
         tick(1);
         chk_st(PRSC_ST_RUN);
         chk("cfg_opts", cap, opts);
         chk1("bus_out_en", 1'b1, oe);
         chk1("cfg_valid", 1'b1, cfg_ok);
         chk1("int_reset", 1'b0, int_rst);
         chk1("cache_inval", 1'b0, inval);
         pins = ~pins;
         tick(2);
         chk("cfg_opts", cap, opts);
      end
      halt_n = 1'b0;
      tick(1);
      chk_st(PRSC_ST_HALT);
      chk1("halt_ack", 1'b1, hack);
      idle_n = 1'b0;
      tick(1);
      chk1("halt_ack", 1'b0, hack);
      chk_st(PRSC_ST_SLEEP);
      chk1("pll_en", 1'b1, pll);
      for (int i = 0; i < 8; i++)
      begin
         seed = xs(seed);
         {snp, intr, halt_n, bclk} = (i == 7) ? 4'hf : seed[3:0];
         tick(1);
         chk_st(PRSC_ST_SLEEP);
         chk1("snoop_accept", 1'b0, snp_acc);
         chk1("intr_accept", 1'b0, intr_acc);
         chk1("pll_en", bclk, pll);
      end
      {snp, intr, halt_n, bclk, idle_n} = 5'h03;
      tick(1);
      chk_st(PRSC_ST_HALT);
      {snp, intr} = 2'b11;
      tick(1);
      chk1("intr_accept", 1'b1, intr_acc);
      chk1("snoop_accept", 1'b1, snp_acc);
      halt_n = 1'b1;
      tick(1);
      chk_st(PRSC_ST_RUN);
      finish_test();
   end
endmodule
`default_nettype wire
